// ---- rtl/rfcwd_decoder.sv ----
// config word decoder: settings byte, receiver entry and derived controls
//
// Local design decision: the plain strobed port.
module rfcwd_decoder
    import rfcwd_pkg::*;
#(
    parameter int DELAY_W = 8
) (
    input wire logic ref_clk_in, // device clock, 25 MHz
    input wire logic rst_in, // synchronous reset, active high
    input wire logic [7:0] addr_in, // register address
    input wire logic [31:0] wdata_in, // write data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    input wire logic [3:0] tech_sel_in, // active technology and rate index
    output logic [31:0] rdata_out, // read data, cycle after read
    output logic auto_rx_delay_enable_out, // automatic receive delay on
    output logic [1:0] timer_sel_out, // selected interface timer
    output logic regulated_output_supply_out, // regulated supply on
    output logic agc_trim_sum_enable_out, // trim sum mode
    output logic [7:0] agc_trim_out, // effective AGC trim
    output logic [3:0] power_control_gear_out, // gear from entry
    output logic [1:0] rx_gain_adjust_out, // sign + magnitude
    output logic [1:0] receive_highpass_corner_adjust_out, // sign + magnitude
    output logic entry_applies_out, // entry mask covers active tech
    output logic [DELAY_W+2:0] rx_delay_out // derived receive delay
);
    // refuse widths the readback and scaling cannot serve
    if (DELAY_W < 8) begin : g_narrow
        $error("DELAY_W must be at least 8");
    end
    // readback word leaves room for at most 28 bits plus growth
    if (DELAY_W > 28) begin : g_wide
        $error("DELAY_W must be at most 28");
    end
    // hit vector covers sixteen technology indices
    if (ENTRY_MASK_W > 16) begin : g_mask
        $error("selection mask wider than the index range");
    end

    logic [7:0] misc;
    logic [31:0] entry;
    logic [7:0] delay_a, delay_b, delay_f, stored_trim;
    logic [7:0] sys_trim;
    logic [7:0] next_misc, next_delay_a, next_delay_b, next_delay_f;
    logic [7:0] next_stored_trim, next_sys_trim;
    logic [31:0] next_entry, next_rdata;
    logic [DELAY_W+2:0] next_delay;
    logic [7:0] next_trim;
    // decoded output next values
    logic next_auto_delay, next_supply, next_trim_sum, next_applies;
    logic [1:0] next_timer, next_gain, next_corner;
    logic [3:0] next_gear;
    logic [15:0] tech_hit;

    // per-index mask hit; indices past mode 3 never apply
    for (genvar gi = 0; gi < 16; gi++) begin : g_hit
        if (gi < ENTRY_MASK_W) begin : g_on
            assign tech_hit[gi] = entry[ENTRY_MASK_LSB+gi];
        end else begin : g_off
            assign tech_hit[gi] = 1'b0;
        end
    end

    // settings byte controls
    always_comb begin
        next_auto_delay = misc[MISC_AUTO_DELAY_BIT];
        next_timer = misc[MISC_TIMER_LSB+:2];
        next_supply = misc[MISC_SUPPLY_BIT];
        next_trim_sum = misc[MISC_TRIM_SUM_BIT];
    end

    // receiver entry fields and mask hit
    always_comb begin
        next_gear = entry[ENTRY_GEAR_LSB+:4];
        next_gain = entry[ENTRY_GAIN_LSB+:2];
        next_corner = entry[ENTRY_HPC_LSB+:2];
        next_applies = tech_hit[tech_sel_in];
    end

    // delay scaling: shift of base by distance from top rate
    function automatic logic [DELAY_W+2:0] rfcwd_scale(input logic [7:0] base,
                                                       input logic [1:0] sh);
        logic [DELAY_W+2:0] b;
        b = {{(DELAY_W-5){1'b0}}, base};
        return b << sh;
    endfunction

    // register writes, reserved bits dropped
    always_comb begin
        next_misc = misc;
        next_entry = entry;
        next_delay_a = delay_a;
        next_delay_b = delay_b;
        next_delay_f = delay_f;
        next_stored_trim = stored_trim;
        next_sys_trim = sys_trim;
        if (wr_in) begin
            if (addr_in == MISC_SETTINGS_OFFSET) begin
                next_misc = wdata_in[7:0] & MISC_WRITE_MASK;
            end else if (addr_in == RX_ENTRY_OFFSET) begin
                next_entry = wdata_in & ENTRY_WRITE_MASK;
            end else if (addr_in == DELAY_A_OFFSET) begin
                next_delay_a = wdata_in[7:0];
            end else if (addr_in == DELAY_B_OFFSET) begin
                next_delay_b = wdata_in[7:0];
            end else if (addr_in == DELAY_F_OFFSET) begin
                next_delay_f = wdata_in[7:0];
            end else if (addr_in == AGC_TRIM_OFFSET) begin
                next_stored_trim = wdata_in[7:0];
            end else if (addr_in == SYS_TRIM_OFFSET) begin
                next_sys_trim = wdata_in[SYS_TRIM_LSB+7:SYS_TRIM_LSB];
            end
        end
    end

    // derived delay and trim
    always_comb begin
        next_delay = '0;
        if (misc[MISC_AUTO_DELAY_BIT]) begin
            case (tech_sel_in)
                RFCWD_A848: next_delay = rfcwd_scale(delay_a, 2'd0);
                RFCWD_A424: next_delay = rfcwd_scale(delay_a, 2'd1);
                RFCWD_A212: next_delay = rfcwd_scale(delay_a, 2'd2);
                RFCWD_A106: next_delay = rfcwd_scale(delay_a, 2'd3);
                RFCWD_B848: next_delay = rfcwd_scale(delay_b, 2'd0);
                RFCWD_B424: next_delay = rfcwd_scale(delay_b, 2'd1);
                RFCWD_B212: next_delay = rfcwd_scale(delay_b, 2'd2);
                RFCWD_B106: next_delay = rfcwd_scale(delay_b, 2'd3);
                RFCWD_F424: next_delay = rfcwd_scale(delay_f, 2'd0);
                RFCWD_F212: next_delay = rfcwd_scale(delay_f, 2'd1);
                default: next_delay = '0;
            endcase
        end
        if (misc[MISC_TRIM_SUM_BIT]) begin
            next_trim = 8'(stored_trim + sys_trim);
        end else begin
            next_trim = stored_trim;
        end
    end

    // read data mux
    always_comb begin
        next_rdata = '0;
        if (rd_in) begin
            if (addr_in == MISC_SETTINGS_OFFSET) begin
                next_rdata = {24'h00_0000, misc};
            end else if (addr_in == RX_ENTRY_OFFSET) begin
                next_rdata = entry;
            end else if (addr_in == DELAY_A_OFFSET) begin
                next_rdata = {24'h00_0000, delay_a};
            end else if (addr_in == DELAY_B_OFFSET) begin
                next_rdata = {24'h00_0000, delay_b};
            end else if (addr_in == DELAY_F_OFFSET) begin
                next_rdata = {24'h00_0000, delay_f};
            end else if (addr_in == AGC_TRIM_OFFSET) begin
                next_rdata = {24'h00_0000, stored_trim};
            end else if (addr_in == SYS_TRIM_OFFSET) begin
                next_rdata = {12'h000, sys_trim, 12'h000};
            end else if (addr_in == STATUS_OFFSET) begin
                next_rdata = {23'h00_0000, entry_applies_out, agc_trim_out};
            end else if (addr_in == DELAY_OUT_OFFSET) begin
                next_rdata = {{(29-DELAY_W){1'b0}}, rx_delay_out};
            end
        end
    end

    // register stage, all outputs from flops
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            misc <= MISC_RESET;
            entry <= ENTRY_RESET;
            delay_a <= DELAY_RESET;
            delay_b <= DELAY_RESET;
            delay_f <= DELAY_RESET;
            stored_trim <= TRIM_RESET;
            sys_trim <= TRIM_RESET;
            rdata_out <= '0;
            auto_rx_delay_enable_out <= 1'b0;
            timer_sel_out <= RFCWD_TIMER0;
            regulated_output_supply_out <= 1'b0;
            agc_trim_sum_enable_out <= 1'b0;
            agc_trim_out <= TRIM_RESET;
            power_control_gear_out <= '0;
            rx_gain_adjust_out <= '0;
            receive_highpass_corner_adjust_out <= '0;
            entry_applies_out <= 1'b0;
            rx_delay_out <= '0;
        end else begin
            misc <= next_misc;
            entry <= next_entry;
            delay_a <= next_delay_a;
            delay_b <= next_delay_b;
            delay_f <= next_delay_f;
            stored_trim <= next_stored_trim;
            sys_trim <= next_sys_trim;
            rdata_out <= next_rdata;
            auto_rx_delay_enable_out <= next_auto_delay;
            timer_sel_out <= next_timer;
            regulated_output_supply_out <= next_supply;
            agc_trim_sum_enable_out <= next_trim_sum;
            agc_trim_out <= next_trim;
            power_control_gear_out <= next_gear;
            rx_gain_adjust_out <= next_gain;
            receive_highpass_corner_adjust_out <= next_corner;
            entry_applies_out <= next_applies;
            rx_delay_out <= next_delay;
        end
    end
endmodule

// ---- rtl/rfcwd_pkg.sv ----
// package: register map, field layout and codes for the config word decoder
package rfcwd_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0] MISC_SETTINGS_OFFSET = 8'he8;
    localparam logic [7:0] RX_ENTRY_OFFSET = 8'h98;
    localparam logic [7:0] DELAY_A_OFFSET = 8'he9;
    localparam logic [7:0] DELAY_B_OFFSET = 8'hea;
    localparam logic [7:0] DELAY_F_OFFSET = 8'heb;
    localparam logic [7:0] SYS_TRIM_OFFSET = 8'hd0;
    localparam logic [7:0] AGC_TRIM_OFFSET = 8'hd4;
    localparam logic [7:0] STATUS_OFFSET = 8'hd8;
    localparam logic [7:0] DELAY_OUT_OFFSET = 8'hdc;
    // settings byte field positions
    localparam int MISC_AUTO_DELAY_BIT = 0;
    localparam int MISC_TIMER_LSB = 1;
    localparam int MISC_SUPPLY_BIT = 3;
    localparam int MISC_TRIM_SUM_BIT = 4;
    localparam logic [7:0] MISC_WRITE_MASK = 8'h1f;
    // table entry field positions
    localparam int ENTRY_GEAR_LSB = 0;
    localparam int ENTRY_GAIN_LSB = 4;
    localparam int ENTRY_HPC_LSB = 6;
    localparam int ENTRY_MASK_LSB = 16;
    localparam int ENTRY_MASK_W = 13;
    localparam logic [31:0] ENTRY_WRITE_MASK = 32'h1fff_00ff;
    // system configuration trim field
    localparam int SYS_TRIM_LSB = 12;
    // reset values
    localparam logic [7:0] MISC_RESET = 8'h00;
    localparam logic [31:0] ENTRY_RESET = 32'h0000_0000;
    localparam logic [7:0] DELAY_RESET = 8'h00;
    localparam logic [7:0] TRIM_RESET = 8'h00;
    // selection mask bit indices (relative to field base)
    typedef enum logic [3:0] {
        RFCWD_A106 = 4'h0, RFCWD_A212 = 4'h1, RFCWD_A424 = 4'h2, RFCWD_A848 = 4'h3,
        RFCWD_B106 = 4'h4, RFCWD_B212 = 4'h5, RFCWD_B424 = 4'h6, RFCWD_B848 = 4'h7,
        RFCWD_F212 = 4'h8, RFCWD_F424 = 4'h9, RFCWD_V_ASK100 = 4'ha,
        RFCWD_V_ASK10 = 4'hb, RFCWD_M3 = 4'hc
    } rfcwd_tech_t;
    // timer selection codes
    typedef enum logic [1:0] {
        RFCWD_TIMER0 = 2'b00,
        RFCWD_TIMER1 = 2'b01,
        RFCWD_TIMER2 = 2'b10
    } rfcwd_timer_t;
endpackage

// ---- sim/rfcwd_decoder_monitor.sv ----
// checker: port assertions for the config word decoder
module rfcwd_decoder_monitor
    import rfcwd_pkg::*;
#(
    parameter int DELAY_W = 8
) (
    input wire logic ref_clk_in, // clock
    input wire logic rst_in, // reset
    input wire logic [7:0] addr_in, // address
    input wire logic [31:0] wdata_in, // write data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    input wire logic [3:0] tech_sel_in, // tech index
    input wire logic [31:0] rdata_out, // read data
    input wire logic auto_rx_delay_enable_out, // delay on
    input wire logic [1:0] timer_sel_out, // timer
    input wire logic regulated_output_supply_out, // supply
    input wire logic [3:0] power_control_gear_out, // gear
    input wire logic [1:0] rx_gain_adjust_out, // gain
    input wire logic [1:0] receive_highpass_corner_adjust_out, // corner
    input wire logic entry_applies_out, // mask hit
    input wire logic [DELAY_W+2:0] rx_delay_out // delay
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // write cycles that load the two config words
    sequence s_misc_wr;
        wr_in && addr_in == MISC_SETTINGS_OFFSET;
    endsequence
    sequence s_entry_wr;
        wr_in && addr_in == RX_ENTRY_OFFSET;
    endsequence
    a_rdata_idle: assert property (!rd_in |=> rdata_out == 32'h0)
        else $error("read data not zero outside read");
    a_unmapped_rd: assert property (rd_in && addr_in == 8'h01 |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_misc_reserved: assert property (rd_in && addr_in == MISC_SETTINGS_OFFSET
        |=> rdata_out[31:5] == 27'h0)
        else $error("settings reserved bits not zero");
    a_delay_en: assert property (s_misc_wr |-> ##2
        auto_rx_delay_enable_out == $past(wdata_in[0], 2))
        else $error("delay enable wrong");
    a_timer_sel: assert property (s_misc_wr |-> ##2
        timer_sel_out == $past(wdata_in[2:1], 2))
        else $error("timer select wrong");
    a_supply_ctl: assert property (s_misc_wr |-> ##2
        regulated_output_supply_out == $past(wdata_in[3], 2))
        else $error("supply control wrong");
    a_entry_fields: assert property (s_entry_wr |-> ##2 {receive_highpass_corner_adjust_out,
        rx_gain_adjust_out, power_control_gear_out} == $past(wdata_in[7:0], 2))
        else $error("entry fields wrong");
    a_entry_mask: assert property (s_entry_wr ##1 $stable(tech_sel_in) ##1 $stable(tech_sel_in)
        |-> entry_applies_out == (tech_sel_in < 4'hd &&
        $past(wdata_in[16 + tech_sel_in], 2)))
        else $error("entry mask hit wrong");
    a_delay_off: assert property (!auto_rx_delay_enable_out |-> rx_delay_out == '0)
        else $error("delay not zero while disabled");
endmodule

bind rfcwd_decoder rfcwd_decoder_monitor #(.DELAY_W(DELAY_W)) rfcwd_decoder_monitor_i (.*);

// ---- sim/rfcwd_decoder_tb_top.sv ----
// testbench: register and decode checks for the config word decoder
module rfcwd_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rfcwd_pkg::*;
    logic ref_clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, rd_d = 0;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0, seed = 32'h3a, w, d, rdata_out;
    logic [3:0] tech_sel_in = 4'h0, power_control_gear_out;
    logic auto_rx_delay_enable_out, regulated_output_supply_out, agc_trim_sum_enable_out;
    logic entry_applies_out;
    logic [1:0] timer_sel_out, rx_gain_adjust_out, receive_highpass_corner_adjust_out;
    logic [7:0] agc_trim_out;
    logic [10:0] rx_delay_out, e;
    logic [31:0] exp_q[$];
    int failures = 0, n_checks = 0;
    rfcwd_decoder rfcwd_decoder_i (.*);
    // clock generation
    initial forever #20 ref_clk_in = ~ref_clk_in;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_checks++;
        if (got !== want) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, want);
        end
    endtask
    // one bus cycle; a read notes its expected data
    task automatic bus(input logic w_en, input logic r_en, input logic [7:0] a,
                       input logic [31:0] v);
        @(posedge ref_clk_in);
        wr_in <= w_en;
        rd_in <= r_en;
        addr_in <= a;
        wdata_in <= v;
        if (r_en) exp_q.push_back(v);
    endtask
    // bus idle, new tech index, wait for derived outputs
    task automatic settle(input logic [3:0] t);
        @(posedge ref_clk_in);
        wr_in <= 1'h0;
        rd_in <= 1'h0;
        tech_sel_in <= t;
        repeat (3) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // read data monitor, one cycle after each read
    always @(posedge ref_clk_in) rd_d <= rd_in;
    always @(negedge ref_clk_in) if (rd_d) chk(rdata_out, exp_q.pop_front());
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        failures++;
        wrap_up();
    end
    initial begin
        repeat (20) @(posedge ref_clk_in);
        rst_in <= 1'h0;
        // reset contents, unmapped write and read
        bus(1'h0, 1'h1, MISC_SETTINGS_OFFSET, MISC_RESET);
        bus(1'h0, 1'h1, RX_ENTRY_OFFSET, ENTRY_RESET);
        bus(1'h1, 1'h0, 8'h01, 32'hffff_ffff);
        bus(1'h0, 1'h1, 8'h01, 32'h0);
        // settings byte, every timer code with random other bits
        for (int t = 0; t < 3; t++) begin
            d = (xs() & ~32'h6) | (t << 1);
            bus(1'h1, 1'h0, MISC_SETTINGS_OFFSET, d);
            bus(1'h0, 1'h1, MISC_SETTINGS_OFFSET, d & 32'h1f);
            settle(4'h0);
            chk(auto_rx_delay_enable_out, d[0]);
            chk(timer_sel_out, d[2:1]);
            chk(regulated_output_supply_out, d[3]);
            chk(agc_trim_sum_enable_out, d[4]);
        end
        // receiver entry fields and selection mask for all indices
        w = xs();
        bus(1'h1, 1'h0, RX_ENTRY_OFFSET, w);
        bus(1'h0, 1'h1, RX_ENTRY_OFFSET, w & 32'h1fff_00ff);
        settle(4'h0);
        chk({receive_highpass_corner_adjust_out, rx_gain_adjust_out,
             power_control_gear_out}, w[7:0]);
        for (int t = 0; t < 16; t++) begin
            settle(t[3:0]);
            chk(entry_applies_out, t < 13 ? w[16 + t] : 1'h0);
        end
        // derived delay per technology from the top-rate bases
        w = xs();
        bus(1'h1, 1'h0, DELAY_A_OFFSET, w[7:0]);
        bus(1'h1, 1'h0, DELAY_B_OFFSET, w[15:8]);
        bus(1'h1, 1'h0, DELAY_F_OFFSET, w[23:16]);
        bus(1'h1, 1'h0, MISC_SETTINGS_OFFSET, 32'h1);
        for (int t = 0; t < 14; t++) begin
            settle(t[3:0]);
            if (t < 4) e = w[7:0] << (3 - t);
            else if (t < 8) e = w[15:8] << (7 - t);
            else if (t < 10) e = w[23:16] << (9 - t);
            else e = 11'h0;
            chk(rx_delay_out, e);
        end
        // trim sum on, then off
        bus(1'h1, 1'h0, SYS_TRIM_OFFSET, w);
        bus(1'h1, 1'h0, AGC_TRIM_OFFSET, w[31:24]);
        bus(1'h1, 1'h0, MISC_SETTINGS_OFFSET, 32'h10);
        settle(4'h0);
        chk(agc_trim_out, 8'(w[31:24] + w[19:12]));
        chk(rx_delay_out, 11'h0);
        bus(1'h1, 1'h0, MISC_SETTINGS_OFFSET, 32'h0);
        settle(4'h0);
        chk(agc_trim_out, w[31:24]);
        // readback of trim and delay A and F base registers
        bus(1'h0, 1'h1, SYS_TRIM_OFFSET, {12'h000, w[19:12], 12'h000});
        bus(1'h0, 1'h1, AGC_TRIM_OFFSET, {24'h00_0000, w[31:24]});
        bus(1'h0, 1'h1, DELAY_A_OFFSET, {24'h00_0000, w[7:0]});
        bus(1'h0, 1'h1, DELAY_F_OFFSET, {24'h00_0000, w[23:16]});
        settle(4'h0);
        wrap_up();
    end
endmodule
